// File: sfa_pkg.sv
package sfa_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int          SFA_AW        = 26;        // 64 MB byte address
  localparam int          SFA_OTP_AW    = 9;         // 512 bytes = 4K bits
  localparam int          SFA_BLK_LSB   = 16;        // 64 KB block index
  localparam int          SFA_BLK_W     = 10;        // 1024 blocks
  localparam logic [3:0]  SFA_PROT_ALL  = 4'hB;      // First code that protects all
  localparam logic [8:0]  SFA_ESN_LAST  = 9'h00F;    // End of factory serial
  localparam int          SFA_SEC_FACT  = 0;         // Security bit: factory lock
  localparam int          SFA_SEC_CUST  = 1;         // Security bit: customer lock
  localparam logic [1:0]  SFA_SEG_RST   = 2'h0;      // Segment select after reset
  localparam logic [2:0]  SFA_RD_LAT    = 3'h1;      // Cycles from read request to data
  localparam logic [7:0]  SFA_OTP_BLANK = 8'hFF;

  // ****************************************
  // Command opcodes
  // ****************************************
  localparam logic [7:0] SFA_OP_READ     = 8'h03;
  localparam logic [7:0] SFA_OP_READ4    = 8'h13;
  localparam logic [7:0] SFA_OP_PROG     = 8'h02;
  localparam logic [7:0] SFA_OP_PROG4    = 8'h12;
  localparam logic [7:0] SFA_OP_SE       = 8'h20;
  localparam logic [7:0] SFA_OP_SE4      = 8'h21;
  localparam logic [7:0] SFA_OP_BE32     = 8'h52;
  localparam logic [7:0] SFA_OP_BE32_4   = 8'h5C;
  localparam logic [7:0] SFA_OP_BE       = 8'hD8;
  localparam logic [7:0] SFA_OP_BE4      = 8'hDC;
  localparam logic [7:0] SFA_OP_WIDE_ON  = 8'hB7;    // enter_wide_address_cmd
  localparam logic [7:0] SFA_OP_WIDE_OFF = 8'hE9;    // exit_wide_address_cmd
  localparam logic [7:0] SFA_OP_SEC_ON   = 8'hB1;    // enter_secure_area_cmd
  localparam logic [7:0] SFA_OP_SEC_OFF  = 8'hC1;    // exit_secure_area_cmd
  localparam logic [7:0] SFA_OP_LOCK_WR  = 8'h2F;    // lock_register_write_cmd
  localparam logic [7:0] SFA_OP_LOCK_RD  = 8'h2B;    // lock_register_read_cmd
  localparam logic [7:0] SFA_OP_SEG_WR   = 8'hC5;
  localparam logic [7:0] SFA_OP_SEG_RD   = 8'hC8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SFA_ST_IDLE  = 3'b000,
    SFA_ST_CMD   = 3'b001,
    SFA_ST_ADDR  = 3'b010,
    SFA_ST_WDATA = 3'b011,
    SFA_ST_RDATA = 3'b100,
    SFA_ST_HOLD  = 3'b101,
    SFA_ST_STBY  = 3'b110
  } sfa_state_type;

  typedef enum logic [2:0] {
    SFA_AOP_NONE  = 3'b000,
    SFA_AOP_READ  = 3'b001,
    SFA_AOP_PROG  = 3'b010,
    SFA_AOP_ER4K  = 3'b011,
    SFA_AOP_ER32K = 3'b100,
    SFA_AOP_ER64K = 3'b101
  } sfa_aop_type;

  // Request toward the main array
  typedef struct packed {
    logic              go;     // One-cycle operation strobe
    sfa_aop_type       op;
    logic [SFA_AW-1:0] addr;
    logic              wstb;   // One-cycle program data strobe
    logic [7:0]        wdata;
  } sfa_arr_req_type;

  typedef struct packed {
    logic        valid;
    logic        has_addr;
    logic        force4;   // Always 32-bit address
    logic        is_read;
    logic        has_wdata;
    sfa_aop_type aop;
  } sfa_info_type;

  // Decode an opcode into its framing properties
  function automatic sfa_info_type sfa_decode(input logic [7:0] op);
    sfa_info_type d;
    d = '{valid: 1'b1, has_addr: 1'b0, force4: 1'b0, is_read: 1'b0,
          has_wdata: 1'b0, aop: SFA_AOP_NONE};
    case (op)
      SFA_OP_READ:     begin d.has_addr = 1'b1; d.is_read = 1'b1; d.aop = SFA_AOP_READ; end
      SFA_OP_READ4:    begin d.has_addr = 1'b1; d.is_read = 1'b1; d.force4 = 1'b1; d.aop = SFA_AOP_READ; end
      SFA_OP_PROG:     begin d.has_addr = 1'b1; d.has_wdata = 1'b1; d.aop = SFA_AOP_PROG; end
      SFA_OP_PROG4:    begin d.has_addr = 1'b1; d.has_wdata = 1'b1; d.force4 = 1'b1; d.aop = SFA_AOP_PROG; end
      SFA_OP_SE:       begin d.has_addr = 1'b1; d.aop = SFA_AOP_ER4K; end
      SFA_OP_SE4:      begin d.has_addr = 1'b1; d.force4 = 1'b1; d.aop = SFA_AOP_ER4K; end
      SFA_OP_BE32:     begin d.has_addr = 1'b1; d.aop = SFA_AOP_ER32K; end
      SFA_OP_BE32_4:   begin d.has_addr = 1'b1; d.force4 = 1'b1; d.aop = SFA_AOP_ER32K; end
      SFA_OP_BE:       begin d.has_addr = 1'b1; d.aop = SFA_AOP_ER64K; end
      SFA_OP_BE4:      begin d.has_addr = 1'b1; d.force4 = 1'b1; d.aop = SFA_AOP_ER64K; end
      SFA_OP_LOCK_RD,
      SFA_OP_SEG_RD:   d.is_read = 1'b1;
      SFA_OP_SEG_WR:   d.has_wdata = 1'b1;
      SFA_OP_WIDE_ON,
      SFA_OP_WIDE_OFF,
      SFA_OP_SEC_ON,
      SFA_OP_SEC_OFF,
      SFA_OP_LOCK_WR:  d.valid = 1'b1;
      default:         d.valid = 1'b0;
    endcase
    return d;
  endfunction

  // Block protection from level code and bottom selector
  function automatic logic sfa_protected(input logic [3:0] lvl, input logic bottom,
                                         input logic [SFA_BLK_W-1:0] blk);
    logic [SFA_BLK_W:0] n;
    n = '0;
    if (lvl != 4'h0)
      n = (SFA_BLK_W+1)'(1) << (lvl - 4'h1);
    if (lvl >= SFA_PROT_ALL)
      return 1'b1;
    if (bottom)
      return {1'b0, blk} < n;
    return {1'b0, blk} >= ((SFA_BLK_W+1)'(1 << SFA_BLK_W) - n);
  endfunction

endpackage

// File: sfa_otp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_otp_mem #(
  parameter int AW = 9
) (
  // Clock and reset
  input  wire  logic          i_ref_clk,
  input  wire  logic          i_rst,
  // Access
  input  wire  logic          i_we,
  input  wire  logic          i_re,
  input  wire  logic [AW-1:0] i_addr,
  input  wire  logic [7:0]    i_wdata,
  output var   logic [7:0]    o_rdata
);
  import sfa_pkg::*;

  typedef struct packed {
    logic [(1<<AW)-1:0][7:0] mem;
    logic [7:0]              rdata;
  } sfa_otp_state_type;

  sfa_otp_state_type r;
  sfa_otp_state_type r_nxt;

  // Programming only clears bits; cells return to one only when reset loads the blank value
  always_comb
  begin
    r_nxt = r;
    if (i_we)
      r_nxt.mem[i_addr] = r.mem[i_addr] & i_wdata;
    if (i_re)
      r_nxt.rdata = r.mem[i_addr];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      r <= '{mem: {(1<<AW){SFA_OTP_BLANK}}, rdata: 8'h00};
    else
      r <= r_nxt;
  end

  assign o_rdata = r.rdata;

endmodule
`default_nettype wire

// File: sfa_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_front_end (
  // Clock and reset
  input  wire  logic                     i_ref_clk,
  input  wire  logic                     i_rst,
  // Serial pins
  input  wire  logic                     i_sclk,
  input  wire  logic                     i_cs_n,
  input  wire  logic                     i_si,
  output var   logic                     o_so,
  output var   logic                     o_so_oe,
  // Status and straps from device logic
  input  wire  logic [3:0]               i_protect_level,
  input  wire  logic                     i_bottom_sel,
  input  wire  logic                     i_factory_lock,
  input  wire  logic                     i_busy,
  // Main array side
  output var   sfa_pkg::sfa_arr_req_type o_arr,
  input  wire  logic [7:0]               i_arr_rdata,
  // Visible state
  output var   logic [7:0]               o_seg_ext,
  output var   logic                     o_wide_flag,
  output var   logic                     o_sec_mode,
  output var   logic [1:0]               o_sec_lock,
  output var   logic                     o_reject
);
  import sfa_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]        sclk_q;
    logic [2:0]        cs_q;
    logic [1:0]        si_q;
    sfa_state_type     st;
    logic [2:0]        bitcnt;
    logic [2:0]        ocnt;
    logic [7:0]        shreg;
    logic [7:0]        oshift;
    logic [7:0]        opcode;
    sfa_info_type      info;
    logic [2:0]        addr_left;
    logic [31:0]       addr_raw;
    logic [SFA_AW-1:0] addr;
    logic              have_data;
    logic [7:0]        wbyte;
    logic [7:0]        rd_byte;
    logic [2:0]        rd_wait;
    logic              rd_otp;
    logic              otp_re;
    logic              otp_we;
    logic              so;
    logic              so_oe;
    sfa_arr_req_type   arr;
    logic [7:0]        seg;
    logic              wide;
    logic              sec_mode;
    logic [1:0]        lock;
    logic              reject;
  } sfa_fe_state_type;

  sfa_fe_state_type r;
  sfa_fe_state_type r_nxt;
  logic [7:0]       otp_rdata;

  // ****************************************
  // Secure one-time area
  // ****************************************
  sfa_otp_mem #(
    .AW (SFA_OTP_AW)
  ) u_otp (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we      (r.otp_we),
    .i_re      (r.otp_re),
    .i_addr    (r.addr[SFA_OTP_AW-1:0]),
    .i_wdata   (r.wbyte),
    .o_rdata   (otp_rdata)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic              rise;
    logic              fall;
    logic              cs_rise;
    logic              cs_fall;
    logic              si;
    logic              byte_done;
    logic [7:0]        byte_in;
    logic [31:0]       araw;
    logic [SFA_AW-1:0] eff;
    sfa_info_type      d;
    logic              prot;
    logic              area_locked;
    r_nxt = r;
    // Clock and select pass three flops, data two; edges are taken from the second and third
    r_nxt.sclk_q = {r.sclk_q[1:0], i_sclk};
    r_nxt.cs_q   = {r.cs_q[1:0], i_cs_n};
    r_nxt.si_q   = {r.si_q[0], i_si};
    rise      = r.sclk_q[1] & ~r.sclk_q[2];
    fall      = ~r.sclk_q[1] & r.sclk_q[2];
    cs_rise   = r.cs_q[1] & ~r.cs_q[2];
    cs_fall   = ~r.cs_q[1] & r.cs_q[2];
    si        = r.si_q[1];
    byte_done = (r.bitcnt == 3'h7);
    byte_in   = {r.shreg[6:0], si};
    araw      = {r.addr_raw[30:0], si};
    d         = sfa_decode(byte_in);
    // Wide mode or 4-byte commands ignore the segment register
    eff = (r.wide || r.info.force4) ? araw[SFA_AW-1:0]
                                    : {r.seg[1:0], araw[23:0]};
    prot        = sfa_protected(i_protect_level, i_bottom_sel,
                                r.addr[SFA_AW-1:SFA_BLK_LSB]);
    area_locked = (r.addr[SFA_OTP_AW-1:0] <= SFA_ESN_LAST) ? r.lock[SFA_SEC_FACT]
                                                           : r.lock[SFA_SEC_CUST];
    // One-cycle strobes
    r_nxt.arr.go   = 1'b0;
    r_nxt.arr.wstb = 1'b0;
    r_nxt.otp_re   = 1'b0;
    r_nxt.otp_we   = 1'b0;
    r_nxt.reject   = 1'b0;
    // Factory lock is set by its strap after reset and then held until reset
    r_nxt.lock[SFA_SEC_FACT] = r.lock[SFA_SEC_FACT] | i_factory_lock;
    // Read data land in the byte buffer once the source has answered
    if (r.rd_wait != 3'h0)
    begin
      r_nxt.rd_wait = r.rd_wait - 3'h1;
      if (r.rd_wait == 3'h1)
        r_nxt.rd_byte = r.rd_otp ? otp_rdata : i_arr_rdata;
    end

    if (cs_rise)
    begin
      // Select high ends any transfer at once, reads included
      r_nxt.st    = SFA_ST_IDLE;
      r_nxt.so_oe = 1'b0;
      if (r.st == SFA_ST_HOLD || r.st == SFA_ST_WDATA || r.st == SFA_ST_ADDR)
      begin
        if (r.bitcnt != 3'h0 || r.st == SFA_ST_ADDR
            || (r.st == SFA_ST_WDATA && !r.have_data))
          r_nxt.reject = 1'b1;
        else
        begin
          case (r.opcode)
            SFA_OP_WIDE_ON:  r_nxt.wide = 1'b1;
            SFA_OP_WIDE_OFF: r_nxt.wide = 1'b0;
            SFA_OP_SEC_ON:   r_nxt.sec_mode = 1'b1;
            SFA_OP_SEC_OFF:  r_nxt.sec_mode = 1'b0;
            SFA_OP_LOCK_WR:  r_nxt.lock[SFA_SEC_CUST] = 1'b1;
            SFA_OP_SEG_WR:   r_nxt.seg = {6'h00, r.wbyte[1:0]};
            default:
            begin
              if (r.sec_mode && r.info.aop == SFA_AOP_PROG)
              begin
                // Programs go to the one-time area, never past a lock
                if (area_locked)
                  r_nxt.reject = 1'b1;
                else
                  r_nxt.otp_we = 1'b1;
              end
              else if (r.sec_mode || i_busy || prot)
                r_nxt.reject = 1'b1;
              else
              begin
                r_nxt.arr.go   = 1'b1;
                r_nxt.arr.op   = r.info.aop;
                r_nxt.arr.addr = r.addr;
              end
            end
          endcase
        end
      end
    end
    else if (cs_fall)
    begin
      r_nxt.st        = SFA_ST_CMD;
      r_nxt.bitcnt    = 3'h0;
      r_nxt.have_data = 1'b0;
      r_nxt.so_oe     = 1'b0;
    end
    else if (rise && r.st != SFA_ST_IDLE && r.st != SFA_ST_STBY)
    begin
      r_nxt.bitcnt = r.bitcnt + 3'h1;
      r_nxt.shreg  = byte_in;
      unique case (r.st)
        SFA_ST_CMD:
        begin
          if (byte_done)
          begin
            r_nxt.opcode    = byte_in;
            r_nxt.info      = d;
            r_nxt.addr_left = (d.force4 || r.wide) ? 3'h4 : 3'h3;
            r_nxt.ocnt      = 3'h0;
            r_nxt.rd_byte   = (byte_in == SFA_OP_LOCK_RD) ? {6'h00, r.lock} : r.seg;
            if (!d.valid)
              r_nxt.st = SFA_ST_STBY;
            else if (d.has_addr)
              r_nxt.st = SFA_ST_ADDR;
            else if (d.is_read)
              r_nxt.st = SFA_ST_RDATA;
            else if (d.has_wdata)
              r_nxt.st = SFA_ST_WDATA;
            else
              r_nxt.st = SFA_ST_HOLD;
          end
        end
        SFA_ST_ADDR:
        begin
          r_nxt.addr_raw = araw;
          if (byte_done)
          begin
            r_nxt.addr_left = r.addr_left - 3'h1;
            if (r.addr_left == 3'h1)
            begin
              r_nxt.addr = eff;
              if (!r.info.is_read)
                r_nxt.st = r.info.has_wdata ? SFA_ST_WDATA : SFA_ST_HOLD;
              else if (i_busy && !r.sec_mode)
                r_nxt.st = SFA_ST_STBY;
              else
              begin
                // Fetch the first byte before the first output edge
                r_nxt.st      = SFA_ST_RDATA;
                r_nxt.rd_otp  = r.sec_mode;
                r_nxt.otp_re  = r.sec_mode;
                r_nxt.arr.go  = !r.sec_mode;
                r_nxt.arr.op  = SFA_AOP_READ;
                r_nxt.arr.addr = eff;
                r_nxt.rd_wait = SFA_RD_LAT + 3'h1;
              end
            end
          end
        end
        SFA_ST_WDATA:
        begin
          if (byte_done)
          begin
            r_nxt.have_data = 1'b1;
            if (!r.have_data)
              r_nxt.wbyte = byte_in;
            // Page data stream to the array buffer; a byte that completes while busy is dropped, not strobed later
            if (r.info.aop == SFA_AOP_PROG && !r.sec_mode && !i_busy)
            begin
              r_nxt.arr.wstb  = 1'b1;
              r_nxt.arr.wdata = byte_in;
            end
          end
        end
        default:
        begin
          r_nxt.st = r.st;
        end
      endcase
    end
    else if (fall && r.st == SFA_ST_RDATA)
    begin
      // Output changes only on the falling edge
      r_nxt.so_oe = 1'b1;
      r_nxt.ocnt  = r.ocnt + 3'h1;
      if (r.ocnt == 3'h0)
      begin
        r_nxt.so     = r.rd_byte[7];
        r_nxt.oshift = {r.rd_byte[6:0], 1'b0};
        if (r.info.has_addr)
        begin
          // Prefetch next byte; the carry runs across segment bounds
          r_nxt.addr     = r.addr + SFA_AW'(1);
          r_nxt.otp_re   = r.rd_otp;
          r_nxt.arr.go   = !r.rd_otp && !i_busy;
          r_nxt.arr.op   = SFA_AOP_READ;
          r_nxt.arr.addr = r.addr + SFA_AW'(1);
          r_nxt.rd_wait  = SFA_RD_LAT + 3'h1;
        end
      end
      else
      begin
        r_nxt.so     = r.oshift[7];
        r_nxt.oshift = {r.oshift[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      r      <= '0;
      r.sclk_q <= 3'h0;
      r.cs_q <= 3'h7;                                           // Deselected at reset
      r.st   <= SFA_ST_IDLE;
      r.seg  <= {6'h00, SFA_SEG_RST};
    end
    else
      r <= r_nxt;
  end

  // Outputs straight from the state register
  assign o_so        = r.so;
  assign o_so_oe     = r.so_oe;
  assign o_arr       = r.arr;
  assign o_seg_ext   = r.seg;
  assign o_wide_flag = r.wide;
  assign o_sec_mode  = r.sec_mode;
  assign o_sec_lock  = r.lock;
  assign o_reject    = r.reject;

endmodule
`default_nettype wire

// File: sfa_front_end_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_front_end_chk (
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst,
  // Watched pins and state
  input  wire logic                     i_sclk,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_busy,
  input  wire logic                     o_so,
  input  wire logic                     o_so_oe,
  input  wire sfa_pkg::sfa_arr_req_type o_arr,
  input  wire logic [7:0]               o_seg_ext,
  input  wire logic                     o_wide_flag,
  input  wire logic                     o_sec_mode,
  input  wire logic [1:0]               o_sec_lock,
  input  wire logic                     o_reject
);
  import sfa_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // Select high long enough to cover the pin synchroniser
  sequence s_cs_idle;
    i_cs_n [*6];
  endsequence
  // Busy seen across the registered request path
  sequence s_busy_held;
    i_busy [*2];
  endsequence
  chk_seg_upper: assert property (o_seg_ext[7:2] == 6'h0)
    else $error("segment upper bits set");
  chk_rst_clear: assert property (disable iff (1'b0)
    i_rst |=> o_seg_ext == 8'h0 && !o_wide_flag && !o_sec_mode && !o_so_oe) else $error("reset state wrong");
  chk_lock_keep: assert property ((($past(o_sec_lock) & ~o_sec_lock) == 2'b00))
    else $error("lock bit cleared");
  chk_sec_noarr: assert property (o_sec_mode |-> !o_arr.go)
    else $error("array request in secure mode");
  chk_busy_noarr: assert property (s_busy_held |=> !o_arr.go)
    else $error("array request while busy");
  chk_reject_pulse: assert property (o_reject |=> !o_reject)
    else $error("reject longer than one cycle");
  chk_reject_nogo: assert property (o_reject |-> !o_arr.go)
    else $error("refused command reached array");
  chk_idle_hiz: assert property (s_cs_idle |-> !o_so_oe)
    else $error("output driven while deselected");
  chk_so_edge: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !i_sclk)
    else $error("output changed with clock high");
endmodule
bind sfa_front_end sfa_front_end_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(i_sclk),
  .i_cs_n(i_cs_n), .i_busy(i_busy), .o_so(o_so), .o_so_oe(o_so_oe), .o_arr(o_arr), .o_seg_ext(o_seg_ext),
  .o_wide_flag(o_wide_flag), .o_sec_mode(o_sec_mode), .o_sec_lock(o_sec_lock), .o_reject(o_reject));
`default_nettype wire

// File: sfa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_host_model (
  // Clock
  input  wire logic i_ref_clk,
  // Serial pins
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_si,
  input  wire logic i_so
);
  logic cpol;  // Clock idle level, mode 0 or 3
  // Idle bus at time zero
  initial
  begin
    cpol = 1'b0;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // One frame: n bits out MSB first, nr bits in; each phase 5 cycles
  task automatic xfer(input logic [63:0] v, input int n, input int nr, output logic [7:0] rd);
    rd = 8'h00;
    o_sclk = cpol;
    repeat (2) @(negedge i_ref_clk);
    o_cs_n = 1'b0;
    for (int k = 0; k < n + nr; k++)
    begin
      repeat (5) @(negedge i_ref_clk);
      o_sclk = 1'b0;
      if (k < n) o_si = v[63-k];
      repeat (5) @(negedge i_ref_clk);
      if (k >= n) rd = {rd[6:0], i_so};
      o_sclk = 1'b1;
    end
    repeat (5) @(negedge i_ref_clk);
    o_sclk = cpol;  // Clock parks at its idle level
    o_si = ~o_si;  // Released line must not show a stale bit
    repeat (2) @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    repeat (10) @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// File: tb_serial_flash_access_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_access_front_end;
  import sfa_pkg::*;
  logic clk, rst, sclk, cs_n, si, so, so_oe, bot, busy, flock, rej, wide, smode, so_last, p;
  logic [3:0]      lvl;
  logic [7:0]      ard, seg, rd, wd;
  logic [1:0]      slock;
  logic [9:0]      bk;
  logic [25:0]     a_first, ea;
  logic [31:0]     lf;
  sfa_arr_req_type arr;
  sfa_aop_type     a_op;
  int              error_cnt, checks_done, go_n, rej_n, oe_n, ws_n;
  localparam logic [7:0]  EOP [3] = '{SFA_OP_SE4, SFA_OP_BE32_4, SFA_OP_BE4};
  localparam sfa_aop_type EAOP [3] = '{SFA_AOP_ER4K, SFA_AOP_ER32K, SFA_AOP_ER64K};
  // 250 MHz reference clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  sfa_front_end DUT (.i_ref_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .i_protect_level(lvl), .i_bottom_sel(bot), .i_factory_lock(flock), .i_busy(busy),
    .o_arr(arr), .i_arr_rdata(ard), .o_seg_ext(seg), .o_wide_flag(wide), .o_sec_mode(smode),
    .o_sec_lock(slock), .o_reject(rej));
  sfa_host_model HOST (.i_ref_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
    .i_so(so_oe ? so : ~so_last));
  function automatic logic [7:0] pat(input logic [25:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {6'h0, a[25:24]};
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected protection of one 64 KB block
  function automatic logic prot(input logic [3:0] l, input logic b, input logic [9:0] k);
    logic [10:0] n;
    n = (l == 4'h0) ? 11'h000 : 11'h001 << (l - 4'h1);
    if (l >= 4'hB) return 1'b1;
    return b ? ({1'b0, k} < n) : ({1'b0, k} >= 11'h400 - n);
  endfunction
  // Array stand-in answers a read one cycle later and churns otherwise; monitor counts pulses
  always @(posedge clk)
  begin
    ard <= (arr.go && arr.op == SFA_AOP_READ) ? pat(arr.addr) : ~ard;
    if (so_oe) so_last <= so;
    if (so_oe) oe_n++;
    if (rej) rej_n++;
    if (arr.go && go_n == 0)
    begin
      a_op    = arr.op;
      a_first = arr.addr;
    end
    if (arr.go) go_n++;
    // Program data strobes, last byte kept for the compare
    if (arr.wstb)
    begin
      ws_n++;
      wd = arr.wdata;
    end
  end
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fr(input logic [63:0] v, input int n, input int nr);
    go_n = 0;
    rej_n = 0;
    oe_n = 0;
    ws_n = 0;
    HOST.xfer(v, n, nr, rd);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: about five times the expected run
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    // Reset high, straps low, factory lock open until the secure-area tests
    {rst, lvl, bot, busy, flock, ard, so_last} = {8'h80, 8'h00, 1'b0};
    {error_cnt, checks_done} = 64'h0;
    lf = 32'h193890e6;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    cmp({seg, wide, smode, slock}, 0);
    fr({SFA_OP_SEG_WR, 8'hFF, 48'h0}, 16, 0);
    cmp(seg, 8'h03);
    HOST.cpol = 1'b1;
    fr({SFA_OP_SEG_RD, 56'h0}, 8, 8);
    cmp(rd, 8'h03);
    HOST.cpol = 1'b0;
    fr({SFA_OP_SEG_WR, 8'h01, 48'h0}, 16, 0);
    // Read from the last byte of segment 1 runs on into segment 2
    fr({SFA_OP_READ, 24'hFFFFFF, 32'h0}, 32, 16);
    cmp(a_first, 26'h1FFFFFF);
    cmp({rd, seg}, {pat(26'h2000000), 8'h01});
    fr({SFA_OP_WIDE_ON, 56'h0}, 8, 0);
    cmp(wide, 1'b1);
    fr({SFA_OP_READ, 32'h00123456, 24'h0}, 40, 8);
    cmp({a_first, rd}, {26'h0123456, pat(26'h0123456)});
    fr({SFA_OP_WIDE_OFF, 56'h0}, 8, 0);
    cmp(wide, 1'b0);
    fr({SFA_OP_READ4, 32'h03000010, 24'h0}, 40, 8);
    cmp(a_first, 26'h3000010);
    // Random protect codes around the protected-range edges, modes 0 and 3
    for (int i = 0; i < 24; i++)
    begin
      lf = nxt(lf);
      {lvl, bot, HOST.cpol} = {lf[3:0], lf[4], lf[17]};
      bk = lf[5] ? lf[15:6] : (bot ? 10'h0 : 10'h0 - 10'(11'h1 << (lvl - 4'h1))) + 10'(lf[16]);
      ea = {bk, lf[31:16]};
      p = prot(lvl, bot, bk);
      fr({EOP[i%3], 6'h0, ea, 24'h0}, 40, 0);
      cmp({go_n, rej_n}, {31'h0, !p, 31'h0, p});
      if (!p) cmp({a_op, a_first[25:16]}, {EAOP[i%3], bk});
    end
    {lvl, HOST.cpol} = 5'h0;
    fr({SFA_OP_SE4, 56'h0}, 43, 0);
    cmp({go_n, rej_n}, {32'h0, 32'h1});
    busy = 1'b1;
    fr({SFA_OP_SE4, 56'h0}, 40, 0);
    cmp(rej_n, 1);
    fr({SFA_OP_READ, 56'h0}, 32, 8);
    cmp({go_n, oe_n}, 0);
    busy = 1'b0;
    fr({8'hFF, 56'h0}, 8, 16);
    cmp(oe_n, 0);
    // Plain page program with a 4-byte address streams its data and commits at select high
    fr({SFA_OP_PROG4, 32'h00001234, 8'hC3, 16'h0}, 48, 0);
    cmp({go_n, ws_n}, {32'h1, 32'h1});
    cmp({a_op, a_first, wd}, {SFA_AOP_PROG, 26'h0001234, 8'hC3});
    fr({SFA_OP_READ, 24'h0000A5, 32'h0}, 32, 3);
    cmp({so_oe, rd[2:0]}, 4'h5);
    // One-time area: program, lock, refuse further change
    flock = 1'b1;
    fr({SFA_OP_LOCK_RD, 56'h0}, 8, 8);  // Status read before the next command
    cmp(rd, 8'h01);
    fr({SFA_OP_SEC_ON, 56'h0}, 8, 0);
    cmp({smode, slock}, 3'h5);
    fr({SFA_OP_PROG, 24'h000020, 8'h5A, 24'h0}, 40, 0);
    fr({SFA_OP_READ, 24'h000020, 32'h0}, 32, 8);
    cmp({go_n, rd}, {32'h0, 8'h5A});
    fr({SFA_OP_PROG, 24'h000005, 8'h00, 24'h0}, 40, 0);
    cmp(rej_n, 1);
    fr({SFA_OP_LOCK_WR, 56'h0}, 8, 0);
    fr({SFA_OP_PROG, 24'h000020, 8'h00, 24'h0}, 40, 0);
    cmp(rej_n, 1);
    fr({SFA_OP_LOCK_RD, 56'h0}, 8, 8);
    cmp(rd[1:0], 2'h3);
    fr({SFA_OP_SEC_OFF, 56'h0}, 8, 0);
    cmp({smode, slock}, 3'h3);
    print_verdict();
  end
endmodule
`default_nettype wire
